/* File: rtl/deio_top.sv */
`timescale 1ns/1ps

// Behaviour
// - Pin setup bit 2 at 0 drives the pin at its idle level, at 1 releases it while idle.
// - Pin setup bit 1 at 0 makes the pin idle high and active low, at 1 active high.
// - With setup bit 0 at 0 each interrupt is one short pulse, and a new one waits for ack.
// - With setup bit 0 at 1 the pin stays active until the host clears the sticky bits.
// - A status change in either direction counts as an event in both pin modes.
// - Loops 1 to 3 each own an event enable register with bits 7, 6, 5, 1 and 0 in use.
// - An enabled status change sets the loop sticky bit, and raises the pin if that bit's pin gate bit is set.
// - A disabled status change neither sets the sticky bit nor touches the pin.
module deio_top import deio_pkg::*; (
  // Clock, reset and clock enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [10:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Loop status from the monitors, same clock domain
  input wire logic [7:0] loop1_status,
  input wire logic [7:0] loop2_status,
  input wire logic [7:0] loop3_status,
  // Interrupt pin, output enable low while driving
  output logic irq_pin_out,
  output logic irq_pin_oe_n,
  // Internal level interrupt
  output logic irq
);

  // Any enabled bit that changed since the last cycle
  function automatic logic loop_event(input logic [7:0] cur, input logic [7:0] prev,
                                      input logic [7:0] en);
    loop_event = |((cur ^ prev) & en & DEIO_LOOP_BITS);
  endfunction

  // Write strobe for one register index
  function automatic logic reg_hit(input logic go, input logic [8:0] cur,
                                   input logic [8:0] at);
    reg_hit = go && (cur == at);
  endfunction

  // Low write byte with unused bits forced to zero
  function automatic logic [7:0] wr_field(input logic [31:0] data, input logic [7:0] keep);
    wr_field = data[7:0] & keep;
  endfunction

  logic [7:0] loop1_en_q;
  logic [7:0] loop2_en_q;
  logic [7:0] loop3_en_q;
  logic [7:0] pin_setup_q;
  logic [7:0] pin_gate_q;
  logic [7:0] active_q;
  logic [7:0] loop1_prev_q;
  logic [7:0] loop2_prev_q;
  logic [7:0] loop3_prev_q;
  logic [7:0] active_set;
  logic [7:0] active_clr;
  logic [7:0] rd_mux;
  logic [8:0] idx;
  logic take;
  logic wr_go;
  logic pending;
  logic pin_active;
  logic [7:0] pulse_cnt_q;
  deio_pin_state_t state_q;
  logic [31:0] avs_readdata_q;
  logic avs_waitrequest_q;
  logic irq_pin_out_q;
  logic irq_pin_oe_n_q;
  logic irq_q;

  // Bus decode
  assign idx = avs_address[10:2];
  assign take = (avs_read | avs_write) & avs_waitrequest_q;
  assign wr_go = avs_write & ~avs_waitrequest_q & avs_byteenable[0];

  // Read multiplexer; unmapped words read as zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (idx)
      DEIO_IDX_LOOP1_EN: rd_mux = loop1_en_q;
      DEIO_IDX_LOOP2_EN: rd_mux = loop2_en_q;
      DEIO_IDX_LOOP3_EN: rd_mux = loop3_en_q;
      DEIO_IDX_PIN_SETUP: rd_mux = pin_setup_q;
      DEIO_IDX_PIN_GATE: rd_mux = pin_gate_q;
      DEIO_IDX_LOOP_RAW: rd_mux = loop1_status & DEIO_LOOP_BITS;
      DEIO_IDX_LOOP_ACTIVE: rd_mux = active_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // One wait cycle per access, then high again
  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_waitrequest_q <= 1'b1;
    end else if (ce) begin
      avs_waitrequest_q <= ~take;
    end
  end

  // Read data latched as the wait drops, held until the next access
  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_readdata_q <= 32'h0000_0000;
    end else if (ce && take) begin
      avs_readdata_q <= {24'h00_0000, rd_mux};
    end
  end

  // Loop 1 event enable, reserved bits stay zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      loop1_en_q <= DEIO_RST_LOOP_EN;
    end else if (ce && reg_hit(wr_go, idx, DEIO_IDX_LOOP1_EN)) begin
      loop1_en_q <= wr_field(avs_writedata, DEIO_LOOP_BITS);
    end
  end

  // Loop 2 event enable
  always_ff @(posedge mclk) begin
    if (rst) begin
      loop2_en_q <= DEIO_RST_LOOP_EN;
    end else if (ce && reg_hit(wr_go, idx, DEIO_IDX_LOOP2_EN)) begin
      loop2_en_q <= wr_field(avs_writedata, DEIO_LOOP_BITS);
    end
  end

  // Loop 3 event enable
  always_ff @(posedge mclk) begin
    if (rst) begin
      loop3_en_q <= DEIO_RST_LOOP_EN;
    end else if (ce && reg_hit(wr_go, idx, DEIO_IDX_LOOP3_EN)) begin
      loop3_en_q <= wr_field(avs_writedata, DEIO_LOOP_BITS);
    end
  end

  // Pin setup, only the three mode bits kept
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_setup_q <= DEIO_RST_PIN_SETUP;
    end else if (ce && reg_hit(wr_go, idx, DEIO_IDX_PIN_SETUP)) begin
      pin_setup_q <= wr_field(avs_writedata, DEIO_PIN_SETUP_BITS);
    end
  end

  // Pin gate; a cleared bit keeps its sticky bit off the pin
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_gate_q <= DEIO_RST_PIN_GATE;
    end else if (ce && reg_hit(wr_go, idx, DEIO_IDX_PIN_GATE)) begin
      pin_gate_q <= wr_field(avs_writedata, DEIO_ACT_BITS);
    end
  end

  // Previous loop 1 status, so both edges of every bit are seen
  always_ff @(posedge mclk) begin
    if (rst) begin
      loop1_prev_q <= 8'h00;
    end else if (ce) begin
      loop1_prev_q <= loop1_status;
    end
  end

  // Previous loop 2 status
  always_ff @(posedge mclk) begin
    if (rst) begin
      loop2_prev_q <= 8'h00;
    end else if (ce) begin
      loop2_prev_q <= loop2_status;
    end
  end

  // Previous loop 3 status
  always_ff @(posedge mclk) begin
    if (rst) begin
      loop3_prev_q <= 8'h00;
    end else if (ce) begin
      loop3_prev_q <= loop3_status;
    end
  end

  // Per-loop event; disabled bits are masked out inside loop_event
  always_comb begin
    active_set = 8'h00;
    active_set[DEIO_ACT_LOOP1] = loop_event(loop1_status, loop1_prev_q, loop1_en_q);
    active_set[DEIO_ACT_LOOP2] = loop_event(loop2_status, loop2_prev_q, loop2_en_q);
    active_set[DEIO_ACT_LOOP3] = loop_event(loop3_status, loop3_prev_q, loop3_en_q);
  end

  // Write one to clear, only on the access edge
  always_comb begin
    active_clr = 8'h00;
    if (wr_go && idx == DEIO_IDX_LOOP_ACTIVE) begin
      active_clr = avs_writedata[7:0] & DEIO_ACT_BITS;
    end
  end

  // Sticky bits; a new event outranks a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      active_q <= DEIO_RST_ACTIVE;
    end else if (ce) begin
      active_q <= (active_q & ~active_clr) | active_set;
    end
  end

  // Pending while any gated sticky bit stands
  assign pending = |(active_q & pin_gate_q);

  // Pin sequencer: pulse or hold, then wait for the host to clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= DEIO_PIN_IDLE;
    end else if (ce) begin
      unique case (state_q)
        DEIO_PIN_IDLE: begin
          if (pending) begin
            if (pin_setup_q[DEIO_PIN_LEVEL]) begin
              state_q <= DEIO_PIN_WAIT_ACK;
            end else begin
              state_q <= DEIO_PIN_PULSE;
            end
          end
        end
        DEIO_PIN_PULSE: begin
          if (pulse_cnt_q == 8'h00) begin
            state_q <= DEIO_PIN_WAIT_ACK;
          end
        end
        DEIO_PIN_WAIT_ACK: begin
          // No new interrupt until every gated bit is cleared
          if (!pending) begin
            state_q <= DEIO_PIN_IDLE;
          end
        end
      endcase
    end
  end

  // Pulse width counter; loaded on the way into the pulse
  always_ff @(posedge mclk) begin
    if (rst) begin
      pulse_cnt_q <= 8'h00;
    end else if (ce) begin
      if (state_q == DEIO_PIN_IDLE && pending &&
          !pin_setup_q[DEIO_PIN_LEVEL]) begin
        pulse_cnt_q <= DEIO_PULSE_LAST;
      end else if (state_q == DEIO_PIN_PULSE && pulse_cnt_q != 8'h00) begin
        pulse_cnt_q <= pulse_cnt_q - 8'h01;
      end
    end
  end

  // Active in the pulse, or through the wait in level mode
  assign pin_active = (state_q == DEIO_PIN_PULSE) ||
                      (state_q == DEIO_PIN_WAIT_ACK && pin_setup_q[DEIO_PIN_LEVEL]);

  // Pin value; registered so the pad never sees decode glitches
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_pin_out_q <= 1'b1;
    end else if (ce) begin
      if (pin_active) begin
        irq_pin_out_q <= pin_setup_q[DEIO_PIN_ACT_HIGH];
      end else begin
        irq_pin_out_q <= ~pin_setup_q[DEIO_PIN_ACT_HIGH];
      end
    end
  end

  // Pin enable; an active pin is always driven, whatever the idle style
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_pin_oe_n_q <= 1'b0;
    end else if (ce) begin
      irq_pin_oe_n_q <= ~pin_active & pin_setup_q[DEIO_PIN_HIGH_Z];
    end
  end

  // Level interrupt for on-chip use, follows pending
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= pending;
    end
  end

  assign avs_readdata = avs_readdata_q;
  assign avs_waitrequest = avs_waitrequest_q;
  assign irq_pin_out = irq_pin_out_q;
  assign irq_pin_oe_n = irq_pin_oe_n_q;
  assign irq = irq_q;

endmodule // deio_top

/* File: rtl/deio_pkg.sv */
package deio_pkg;

  // Register indices; byte address is four times the index
  localparam logic [8:0] DEIO_IDX_LOOP1_EN = 9'h095;
  localparam logic [8:0] DEIO_IDX_LOOP2_EN = 9'h096;
  localparam logic [8:0] DEIO_IDX_LOOP3_EN = 9'h097;
  localparam logic [8:0] DEIO_IDX_PIN_SETUP = 9'h0a4;
  localparam logic [8:0] DEIO_IDX_PIN_GATE = 9'h0f0;
  localparam logic [8:0] DEIO_IDX_LOOP_RAW = 9'h0f1;
  localparam logic [8:0] DEIO_IDX_LOOP_ACTIVE = 9'h184;

  // Values after reset
  localparam logic [7:0] DEIO_RST_LOOP_EN = 8'h00;
  localparam logic [7:0] DEIO_RST_PIN_SETUP = 8'h00;
  localparam logic [7:0] DEIO_RST_PIN_GATE = 8'h0e;
  localparam logic [7:0] DEIO_RST_ACTIVE = 8'h00;

  // Pin setup field positions
  localparam int DEIO_PIN_LEVEL = 0;
  localparam int DEIO_PIN_ACT_HIGH = 1;
  localparam int DEIO_PIN_HIGH_Z = 2;
  localparam logic [7:0] DEIO_PIN_SETUP_BITS = 8'h07;

  // Loop event enable field positions; bits 4..2 reserved
  localparam int DEIO_LOCK_LOSS = 0;
  localparam int DEIO_HOLDOVER_MASK = 1;
  localparam int DEIO_RANGE_LIMIT = 5;
  localparam int DEIO_PHASE_MEM_LIMIT = 6;
  localparam int DEIO_PHASE_SLOPE_LIMIT = 7;
  localparam logic [7:0] DEIO_LOOP_BITS = 8'he3;

  // Sticky bit positions for loops 1..3
  localparam int DEIO_ACT_LOOP1 = 1;
  localparam int DEIO_ACT_LOOP2 = 2;
  localparam int DEIO_ACT_LOOP3 = 3;
  localparam logic [7:0] DEIO_ACT_BITS = 8'h0e;

  // Edge mode pulse width
  localparam int DEIO_CLK_MHZ = 250;
  localparam int DEIO_PULSE_NS = 100;
  localparam int DEIO_PULSE_CYC = (DEIO_PULSE_NS * DEIO_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] DEIO_PULSE_LAST = 8'(DEIO_PULSE_CYC - 1);

  // Pin sequencer
  typedef enum logic [2:0] {
    DEIO_PIN_IDLE = 3'b001,
    DEIO_PIN_PULSE = 3'b010,
    DEIO_PIN_WAIT_ACK = 3'b100
  } deio_pin_state_t;

endpackage

/* File: bench/deio_chk.sv */
`timescale 1ns/1ps
module deio_chk import deio_pkg::*; (
  // Clock and control
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Register bus
  input wire logic [10:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  // Interrupt outputs
  input wire logic irq_pin_out,
  input wire logic irq_pin_oe_n,
  input wire logic irq
);
  logic [2:0] set_q;
  logic [2:0] cfg_q;
  logic [7:0] run_q;
  logic act;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Setup shadow; extra stage because the pin is registered
  always_ff @(posedge mclk) begin
    if (rst) begin
      set_q <= 3'h0;
      cfg_q <= 3'h0;
    end else begin
      if (ce && avs_write && !avs_waitrequest && avs_byteenable[0]
          && avs_address[10:2] == DEIO_IDX_PIN_SETUP) set_q <= avs_writedata[2:0];
      cfg_q <= set_q;
    end
  end
  // Pin active, and for how many cycles
  assign act = !irq_pin_oe_n && irq_pin_out == cfg_q[DEIO_PIN_ACT_HIGH];
  always_ff @(posedge mclk) run_q <= (rst || !act) ? 8'h00 : run_q + 8'h01;
  sequence s_taken; ce && (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_pulse_end; !cfg_q[DEIO_PIN_LEVEL] ##0 $fell(act); endsequence
  a_wait_answer: assert property (s_taken |=> !avs_waitrequest)
    else $error("no answer");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
  a_release_hiz: assert property (irq_pin_oe_n |-> cfg_q[DEIO_PIN_HIGH_Z])
    else $error("pin released while driven idle");
  a_idle_drive: assert property (!cfg_q[DEIO_PIN_HIGH_Z] |-> !irq_pin_oe_n)
    else $error("pin not driven");
  a_level_hold: assert property (cfg_q[DEIO_PIN_LEVEL] && irq && $past(irq) |-> act)
    else $error("level pin not active");
  a_level_drop: assert property (cfg_q[DEIO_PIN_LEVEL] && $fell(irq) |=> !act)
    else $error("level pin stuck");
  a_pulse_width: assert property (s_pulse_end |-> run_q == 8'(DEIO_PULSE_CYC))
    else $error("bad pulse width");
  a_no_repulse: assert property (!cfg_q[0] && irq && $past(irq) && $past(irq, 2)
    |-> !$rose(act))
    else $error("pulse before ack");
endmodule // deio_chk
bind deio_top deio_chk chk_u (.mclk(mclk), .rst(rst), .ce(ce), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .irq_pin_out(irq_pin_out), .irq_pin_oe_n(irq_pin_oe_n), .irq(irq));

/* File: bench/deio_host.sv */
`timescale 1ns/1ps
module deio_host (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Pin and the level taken as active
  input wire logic irq_pin_out,
  input wire logic irq_pin_oe_n,
  input wire logic act_high,
  // What the host sees
  output logic wire_lvl,
  output int pulses
);
  logic seen_q;
  // Board pull-up holds a released line high
  assign wire_lvl = irq_pin_oe_n ? 1'b1 : irq_pin_out;
  // Count entries into the active level
  always_ff @(posedge mclk) begin
    if (rst) begin
      seen_q <= 1'b0;
      pulses <= 0;
    end else begin
      seen_q <= wire_lvl == act_high;
      if (wire_lvl == act_high && !seen_q) pulses <= pulses + 1;
    end
  end
endmodule // deio_host

/* File: bench/deio_top_tb_top.sv */
`timescale 1ns/1ps
module deio_top_tb_top import deio_pkg::*; ();
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic act_high = 1'b0;
  logic [10:0] avs_address = 11'h000;
  logic [31:0] avs_writedata = 32'h0;
  logic [7:0] st1 = 8'h00;
  logic [7:0] st2 = 8'h00;
  logic [7:0] st3 = 8'h00;
  logic [31:0] avs_readdata;
  logic [31:0] q;
  logic avs_waitrequest, irq_pin_out, irq_pin_oe_n, wire_lvl, irq_lvl;
  int pulses, base;
  int mismatches = 0;
  int cmp_count = 0;
  // Device, enable and byte lane 0 fixed on
  deio_top dut_u (.mclk(mclk), .rst(rst), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'h1),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .loop1_status(st1), .loop2_status(st2),
    .loop3_status(st3), .irq_pin_out(irq_pin_out), .irq_pin_oe_n(irq_pin_oe_n), .irq(irq_lvl));
  deio_host host_u (.mclk(mclk), .rst(rst), .irq_pin_out(irq_pin_out),
    .irq_pin_oe_n(irq_pin_oe_n), .act_high(act_high), .wire_lvl(wire_lvl), .pulses(pulses));
  initial begin
    forever #2 mclk = ~mclk;
  end
  task automatic conclude();
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One transfer; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [8:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      conclude();
    end
  endtask
  // Reset values, reserved bits, unmapped index
  task automatic t_regs();
    bus(0, DEIO_IDX_PIN_GATE, 8'h00);
    cmp(q, 32'h0e);
    st1 <= 8'hff;
    bus(0, DEIO_IDX_LOOP_RAW, 8'h00);
    cmp(q, 32'he3);
    st1 <= 8'h00;
    for (int i = 0; i < 3; i++) begin
      bus(0, DEIO_IDX_LOOP1_EN + 9'(i), 8'h00);
      cmp(q, 32'h0);
      bus(1, DEIO_IDX_LOOP1_EN + 9'(i), 8'hff);
      bus(0, DEIO_IDX_LOOP1_EN + 9'(i), 8'h00);
      cmp(q, 32'he3);
    end
    bus(0, DEIO_IDX_PIN_SETUP, 8'h00);
    cmp(q, 32'h0);
    bus(0, 9'h1ff, 8'h00);
    cmp(q, 32'h0);
  endtask
  // Level mode, active high, both change directions, masked changes
  task automatic t_level();
    act_high <= 1'b1;
    bus(1, DEIO_IDX_PIN_SETUP, 8'h03);
    bus(1, DEIO_IDX_LOOP2_EN, 8'h02);
    bus(1, DEIO_IDX_LOOP3_EN, 8'h00);
    repeat (3) @(posedge mclk);
    cmp(32'(wire_lvl), 32'h0);
    st2 <= 8'h02;
    repeat (4) @(posedge mclk);
    cmp(32'(wire_lvl), 32'h1);
    cmp(32'(irq_lvl), 32'h1);
    bus(0, DEIO_IDX_LOOP_ACTIVE, 8'h00);
    cmp(q, 32'h4);
    bus(1, DEIO_IDX_LOOP_ACTIVE, 8'h04);
    repeat (3) @(posedge mclk);
    cmp(32'(wire_lvl), 32'h0);
    cmp(32'(irq_lvl), 32'h0);
    st2 <= 8'h00;
    repeat (4) @(posedge mclk);
    cmp(32'(wire_lvl), 32'h1);
    bus(1, DEIO_IDX_LOOP_ACTIVE, 8'h04);
    bus(1, DEIO_IDX_LOOP2_EN, 8'h1c);
    st2 <= 8'h1c;
    st3 <= 8'hff;
    repeat (4) @(posedge mclk);
    cmp(32'(wire_lvl), 32'h0);
    bus(0, DEIO_IDX_LOOP_ACTIVE, 8'h00);
    cmp(q, 32'h0);
  endtask
  // Edge mode, active low, released when idle; no pulse until ack
  task automatic t_edge();
    act_high <= 1'b0;
    bus(1, DEIO_IDX_PIN_SETUP, 8'h04);
    bus(1, DEIO_IDX_LOOP1_EN, 8'h80);
    repeat (3) @(posedge mclk);
    base = pulses;
    cmp(32'(irq_pin_oe_n), 32'h1);
    st1 <= 8'h80;
    repeat (40) @(posedge mclk);
    cmp(32'(pulses - base), 32'h1);
    st1 <= 8'h00;
    repeat (40) @(posedge mclk);
    cmp(32'(pulses - base), 32'h1);
    bus(0, DEIO_IDX_LOOP_ACTIVE, 8'h00);
    cmp(q, 32'h2);
    bus(1, DEIO_IDX_LOOP_ACTIVE, 8'h02);
    repeat (3) @(posedge mclk);
    st1 <= 8'h80;
    repeat (40) @(posedge mclk);
    cmp(32'(pulses - base), 32'h2);
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_level();
    t_edge();
    conclude();
  end
endmodule // deio_top_tb_top
